// file: rtl/dout_cmd.sv
//Function
//RULE1: set frame is the four-character set prefix then exactly one data byte.
//RULE2: output changes only after the data byte has fully arrived.
//RULE3: data bit 0 low drives output low, bit 0 high drives it high.
//RULE4: data bits 1 to 7 are ignored entirely.
//RULE5: only frames carrying module address 0x30 are acted on.
//RULE6: read command replies one byte: bit 0 output, bit 3 input.
//RULE7: output holds until the next valid set frame; set sends no reply.
`timescale 1ns/1ps
module dout_cmd
  import dout_cmd_pkg::*;
#(
  parameter int BIT_CYCLES = BIT_CYCLES_DEFAULT
)
(
  // clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // serial link
  input wire logic rxd,
  output logic txd_q,
  // digital lines
  input wire logic din,
  output logic dout_q,
  // status
  output logic set_done_q,
  output logic tx_busy_q
);

  // ---------------------------------------------------------------
  // parameter check
  // ---------------------------------------------------------------
  localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(BIT_CYCLES - 1);

  generate
    if (BIT_CYCLES < 4 || BIT_CYCLES >= (1 << CNT_W))
    begin : g_bad_bit_cycles
      // counters are CNT_W wide and the half-bit wait needs a few cycles
      $error("BIT_CYCLES out of range");
    end
  endgenerate

  // ---------------------------------------------------------------
  // receiver
  // ---------------------------------------------------------------
  logic [7:0] rx_byte;
  logic rx_valid;

  serial_byte_rx #(
    .BIT_CYCLES(BIT_CYCLES)
  ) u_rx (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .rxd(rxd),
    .rx_byte_q(rx_byte),
    .rx_valid_q(rx_valid)
  );

  // ---------------------------------------------------------------
  // prefix parser
  // ---------------------------------------------------------------
  parse_state_t pstate_q;
  parse_state_t pstate_d;
  logic set_fire;
  logic read_fire;

  always_comb
  begin
    pstate_d = pstate_q;
    set_fire = 1'b0;
    read_fire = 1'b0;
    if (rx_valid)
    begin
      // any mismatch restarts; outside P_DATA a stray start char begins a new frame
      pstate_d = (rx_byte == CH_START) ? P_BANG : P_IDLE;
      unique case (pstate_q)
        P_IDLE:
        begin
          if (rx_byte == CH_START)
            pstate_d = P_BANG;
        end
        P_BANG:
        begin
          if (rx_byte == MODULE_ADDR)
            pstate_d = P_ADDR; // [RULE5]
        end
        P_ADDR:
        begin
          if (rx_byte == CH_SET)
            pstate_d = P_SET; // [RULE1]
          else if (rx_byte == CH_READ)
            pstate_d = P_READ;
        end
        P_SET:
        begin
          if (rx_byte == CH_SET_TAIL)
            pstate_d = P_DATA; // [RULE1]
        end
        P_DATA:
        begin
          // the data byte is taken whatever its value, even the start char
          pstate_d = P_IDLE;
          set_fire = 1'b1; // [RULE1] [RULE2]
        end
        P_READ:
        begin
          if (rx_byte == CH_READ_TAIL)
          begin
            pstate_d = P_IDLE;
            read_fire = 1'b1; // [RULE6]
          end
        end
        default:
        begin
          pstate_d = P_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      pstate_q <= P_IDLE;
    else if (ce)
      pstate_q <= pstate_d;
  end

  // ---------------------------------------------------------------
  // digital output
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dout_q <= DOUT_RESET;
      set_done_q <= 1'b0;
    end
    else if (ce)
    begin
      set_done_q <= set_fire;
      // only bit 0 reaches the line; the rest of the byte is dropped
      if (set_fire)
        dout_q <= rx_byte[DOUT_DATA_BIT]; // [RULE3] [RULE4] [RULE7]
    end
  end

  // ---------------------------------------------------------------
  // reply transmitter
  // ---------------------------------------------------------------
  tx_state_t tstate_q;
  logic [CNT_W-1:0] tcnt_q;
  logic [8:0] tsr_q;
  logic [3:0] tleft_q;
  logic [7:0] reply;

  always_comb
  begin
    reply = BYTE_RESET;
    reply[REPLY_OUT_BIT] = dout_q; // [RULE6]
    reply[REPLY_IN_BIT] = din; // [RULE6]
  end

  // a read arriving while a reply is still on the wire is dropped;
  // the host waits for each reply, so no queue is kept
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      tstate_q <= TX_IDLE;
      tcnt_q <= '0;
      tsr_q <= '1;
      tleft_q <= '0;
      txd_q <= LINE_IDLE;
      tx_busy_q <= 1'b0;
    end
    else if (ce)
    begin
      unique case (tstate_q)
        TX_IDLE:
        begin
          txd_q <= LINE_IDLE;
          tcnt_q <= '0;
          if (read_fire)
          begin
            tstate_q <= TX_SHIFT;
            tx_busy_q <= 1'b1;
            txd_q <= 1'b0;
            tsr_q <= {LINE_IDLE, reply}; // [RULE6]
            tleft_q <= 4'(DATA_BITS + 1);
          end
        end
        TX_SHIFT:
        begin
          if (tcnt_q == BIT_LAST)
          begin
            tcnt_q <= '0;
            if (tleft_q == 4'h0)
            begin
              tstate_q <= TX_IDLE;
              tx_busy_q <= 1'b0;
            end
            else
            begin
              txd_q <= tsr_q[0];
              tsr_q <= {LINE_IDLE, tsr_q[8:1]};
              tleft_q <= tleft_q - 1'b1;
            end
          end
          else
            tcnt_q <= tcnt_q + 1'b1;
        end
      endcase
    end
  end

endmodule

// file: rtl/dout_cmd_pkg.sv
package dout_cmd_pkg;

  // ---------------------------------------------------------------
  // clock and serial timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ = 25_000_000;
  localparam int BAUD_DEFAULT = 9600;
  // bit time rounded to the nearest whole cycle
  localparam int BIT_CYCLES_DEFAULT = (CLK_HZ + BAUD_DEFAULT / 2) / BAUD_DEFAULT;
  localparam int CNT_W = 16;
  localparam int DATA_BITS = 8;

  // ---------------------------------------------------------------
  // command characters
  // ---------------------------------------------------------------
  localparam logic [7:0] CH_START = 8'h21;
  localparam logic [7:0] MODULE_ADDR = 8'h30;
  localparam logic [7:0] CH_SET = 8'h53;
  localparam logic [7:0] CH_SET_TAIL = 8'h30;
  localparam logic [7:0] CH_READ = 8'h52;
  localparam logic [7:0] CH_READ_TAIL = 8'h44;

  // ---------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------
  localparam int DOUT_DATA_BIT = 0;
  localparam int REPLY_OUT_BIT = 0;
  localparam int REPLY_IN_BIT = 3;
  localparam logic DOUT_RESET = 1'b0;
  localparam logic LINE_IDLE = 1'b1;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // ---------------------------------------------------------------
  // state types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } rx_state_t;

  typedef enum logic [2:0] {
    P_IDLE = 3'b000,
    P_BANG = 3'b001,
    P_ADDR = 3'b010,
    P_SET = 3'b011,
    P_DATA = 3'b100,
    P_READ = 3'b101
  } parse_state_t;

  typedef enum logic {
    TX_IDLE = 1'b0,
    TX_SHIFT = 1'b1
  } tx_state_t;

endpackage

// file: rtl/serial_byte_rx.sv
`timescale 1ns/1ps
module serial_byte_rx
  import dout_cmd_pkg::*;
#(
  parameter int BIT_CYCLES = BIT_CYCLES_DEFAULT
)
(
  // clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // serial line
  input wire logic rxd,
  // received byte
  output logic [7:0] rx_byte_q,
  output logic rx_valid_q
);

  localparam logic [CNT_W-1:0] BIT_LAST = CNT_W'(BIT_CYCLES - 1);
  localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(BIT_CYCLES / 2 - 1);

  rx_state_t state_q;
  logic [CNT_W-1:0] cnt_q;
  logic [2:0] idx_q;
  logic [7:0] shift_q;

  // ---------------------------------------------------------------
  // 8N1 framing, sampled mid-bit
  // ---------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= RX_IDLE;
      cnt_q <= '0;
      idx_q <= '0;
      shift_q <= BYTE_RESET;
      rx_byte_q <= BYTE_RESET;
      rx_valid_q <= 1'b0;
    end
    else if (ce)
    begin
      rx_valid_q <= 1'b0;
      unique case (state_q)
        RX_IDLE:
        begin
          cnt_q <= '0;
          if (!rxd)
            state_q <= RX_START;
        end
        RX_START:
        begin
          if (cnt_q == HALF_LAST)
          begin
            cnt_q <= '0;
            idx_q <= '0;
            // a glitch shorter than half a bit is not a start bit
            state_q <= rxd ? RX_IDLE : RX_DATA;
          end
          else
            cnt_q <= cnt_q + 1'b1;
        end
        RX_DATA:
        begin
          if (cnt_q == BIT_LAST)
          begin
            cnt_q <= '0;
            shift_q <= {rxd, shift_q[7:1]};
            if (idx_q == 3'(DATA_BITS - 1))
              state_q <= RX_STOP;
            else
              idx_q <= idx_q + 1'b1;
          end
          else
            cnt_q <= cnt_q + 1'b1;
        end
        RX_STOP:
        begin
          if (cnt_q == BIT_LAST)
          begin
            cnt_q <= '0;
            state_q <= RX_IDLE;
            // framing error drops the byte silently
            if (rxd)
            begin
              rx_byte_q <= shift_q;
              rx_valid_q <= 1'b1;
            end
          end
          else
            cnt_q <= cnt_q + 1'b1;
        end
      endcase
    end
  end

endmodule

// file: verification/dout_cmd_properties.sv
`timescale 1ns/1ps
module dout_cmd_properties
  import dout_cmd_pkg::*;
#(
  parameter int BIT_CYCLES = BIT_CYCLES_DEFAULT
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic rxd,
  input wire logic txd_q,
  input wire logic din,
  input wire logic dout_q,
  input wire logic set_done_q,
  input wire logic tx_busy_q
);
  // ----
  // reply timing helper
  // ----
  // start, eight data and stop bits, each BIT_CYCLES long
  localparam int FRAME = 10 * BIT_CYCLES;
  localparam int D0 = 2 + 8 * BIT_CYCLES;
  logic [15:0] busy_q;
  // counts with ce assumed high; a frozen clock enable would stretch it
  always_ff @(posedge clk)
  begin
    if (rst || !tx_busy_q)
      busy_q <= 16'h0000;
    else
      busy_q <= busy_q + 16'h0001;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_start_low;
    !txd_q [*4];
  endsequence
  property p_hold;
    $changed(dout_q) |-> set_done_q;
  endproperty
  a_hold: assert property (p_hold) else $error("output moved");
  property p_after_stop;
    set_done_q |-> $past(rxd, 2);
  endproperty
  a_after_stop: assert property (p_after_stop) else $error("early set");
  property p_data;
    set_done_q |-> dout_q == $past(rxd, D0);
  endproperty
  a_data: assert property (p_data) else $error("wrong level");
  property p_idle;
    !tx_busy_q |-> txd_q;
  endproperty
  a_idle: assert property (p_idle) else $error("line not idle");
  property p_start;
    $rose(tx_busy_q) |-> s_start_low;
  endproperty
  a_start: assert property (p_start) else $error("bad start");
  property p_len;
    $fell(tx_busy_q) |-> busy_q == FRAME;
  endproperty
  a_len: assert property (p_len) else $error("bad reply length");
  property p_out_bit;
    busy_q == BIT_CYCLES + 1 + BIT_CYCLES / 2 |-> txd_q == dout_q;
  endproperty
  a_out_bit: assert property (p_out_bit) else $error("bad bit 0");
endmodule
bind dout_cmd dout_cmd_properties #(.BIT_CYCLES(BIT_CYCLES)) u_props (
  .clk(clk), .rst(rst), .ce(ce), .rxd(rxd), .txd_q(txd_q), .din(din),
  .dout_q(dout_q), .set_done_q(set_done_q), .tx_busy_q(tx_busy_q));

// file: verification/host_link.sv
`timescale 1ns/1ps
module host_link
  import dout_cmd_pkg::*;
#(
  parameter int BIT_CYCLES = 16
)
(
  input wire logic clk,
  output logic rxd,
  input wire logic txd_q
);
  // ----
  // host side of the serial link
  // ----
  initial rxd = LINE_IDLE;
  task automatic put(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge clk);
      rxd <= f[i];
      repeat (BIT_CYCLES - 1) @(posedge clk);
    end
  endtask
  // with_data low leaves a prefix hanging, to probe early action
  task automatic send_set(input logic [7:0] a, input logic [7:0] d, input bit with_data);
    put(CH_START);
    put(a);
    put(CH_SET);
    put(CH_SET_TAIL);
    if (with_data)
      put(d);
  endtask
  task automatic send_read(input logic [7:0] a);
    put(CH_START);
    put(a);
    put(CH_READ);
    put(CH_READ_TAIL);
  endtask
  task automatic get(output logic [7:0] b, output bit ok);
    ok = 0;
    b = 8'h00;
    for (int i = 0; i < 60 * BIT_CYCLES && !ok; i++)
    begin
      @(posedge clk);
      ok = (txd_q === 1'b0);
    end
    if (ok)
    begin
      repeat (BIT_CYCLES + BIT_CYCLES / 2) @(posedge clk);
      for (int k = 0; k < 8; k++)
      begin
        b[k] = txd_q;
        repeat (BIT_CYCLES) @(posedge clk);
      end
    end
  endtask
endmodule

// file: verification/dout_cmd_tb.sv
`timescale 1ns/1ps
module dout_cmd_tb;
  import dout_cmd_pkg::*;
  localparam int BC = 16;
  localparam logic [7:0] VALS [6] = '{8'h01, 8'h00, 8'hFF, 8'hFE, 8'h81, 8'h7E};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic din = 1'b0;
  logic exp_dout = DOUT_RESET;
  logic rxd, txd_q, dout_q, set_done_q, tx_busy_q;
  int bad_count = 0;
  int compares = 0;
  int cycles = 0;
  `define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin bad_count++; \
    $display("Error %s expected %0h seen %0h", n, e, g); end end
  always #20 clk = ~clk;
  dout_cmd #(.BIT_CYCLES(BC)) dut (.clk(clk), .rst(rst), .ce(ce), .rxd(rxd),
    .txd_q(txd_q), .din(din), .dout_q(dout_q), .set_done_q(set_done_q),
    .tx_busy_q(tx_busy_q));
  host_link #(.BIT_CYCLES(BC)) host (.clk(clk), .rxd(rxd), .txd_q(txd_q));
  // ----
  // scenarios
  // ----
  task automatic tally_and_finish();
    if (bad_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end
  task automatic wait_set(output bit seen);
    seen = 0;
    for (int i = 0; i < 60 * BC && !seen; i++)
    begin
      @(posedge clk);
      seen = (set_done_q === 1'b1);
    end
  endtask
  task automatic t_set(input logic [7:0] d);
    bit seen;
    fork host.send_set(MODULE_ADDR, d, 1'b1); wait_set(seen); join
    `CHK("set_done", 1'b1, seen)
    `CHK("dout_q", d[DOUT_DATA_BIT], dout_q)
    `CHK("tx_busy", 1'b0, tx_busy_q)
    exp_dout = d[DOUT_DATA_BIT];
  endtask
  task automatic t_no_data();
    logic v;
    bit seen;
    v = exp_dout;
    host.send_set(MODULE_ADDR, 8'h00, 1'b0);
    repeat (4 * BC) @(posedge clk);
    `CHK("dout_q", v, dout_q)
    fork host.put({7'h00, ~v}); wait_set(seen); join
    `CHK("dout_q", ~v, dout_q)
    exp_dout = ~v;
  endtask
  task automatic t_other_addr();
    logic v;
    bit seen;
    v = exp_dout;
    fork host.send_set(8'h31, {7'h00, ~v}, 1'b1); wait_set(seen); join
    `CHK("set_done", 1'b0, seen)
    `CHK("dout_q", v, dout_q)
  endtask
  task automatic t_read(input logic lvl);
    logic [7:0] b;
    bit ok;
    din <= lvl;
    fork host.send_read(MODULE_ADDR); host.get(b, ok); join
    `CHK("reply", 1'b1, ok)
    `CHK("reply", {4'h0, lvl, 2'b00, exp_dout}, b)
  endtask
  // a whole set frame sent while the clock enable is low must leave no trace
  task automatic t_freeze();
    bit seen;
    ce <= 1'b0;
    fork host.send_set(MODULE_ADDR, {7'h00, ~exp_dout}, 1'b1); wait_set(seen); join
    `CHK("set_done", 1'b0, seen)
    `CHK("dout_q", exp_dout, dout_q)
    ce <= 1'b1;
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    `CHK("dout_q", DOUT_RESET, dout_q)
    `CHK("txd_q", LINE_IDLE, txd_q)
    foreach (VALS[i])
      t_set(VALS[i]);
    t_read(1'b1);
    t_no_data();
    t_other_addr();
    t_freeze();
    t_set(8'hFF);
    t_read(1'b0);
    tally_and_finish();
  end
endmodule
